// ==== rtl/afr_pkg.sv ====
package afr_pkg;

  // register offsets (7-bit serial address space)
  localparam logic [6:0] ADDR_LONG_BYTE7   = 7'h69;
  localparam logic [6:0] ADDR_LONG_BYTE8   = 7'h6a;
  localparam logic [6:0] ADDR_SHORT0_LOW   = 7'h6b;
  localparam logic [6:0] ADDR_SHORT0_HIGH  = 7'h6c;
  localparam logic [6:0] ADDR_SHORT1_LOW   = 7'h6d;
  localparam logic [6:0] ADDR_SHORT1_HIGH  = 7'h6e;
  localparam logic [6:0] ADDR_REJ_CNT_LOW  = 7'h6f;
  localparam logic [6:0] ADDR_REJ_CNT_HIGH = 7'h70;
  localparam logic [6:0] ADDR_TX_FIFO      = 7'h7e;
  localparam logic [6:0] ADDR_RX_FIFO      = 7'h7f;
  localparam logic [6:0] ADDR_ONE          = 7'h01;

  // read/write match registers, indexed from the first one
  localparam int         RW_COUNT   = 6;
  localparam logic [7:0] REG_RESET  = 8'h00;
  localparam logic [7:0] READ_ZERO  = 8'h00;

  // filter control fields
  localparam int         FC_LONG_EN_BIT   = 2;
  localparam int         FC_SHORT0_EN_BIT = 3;
  localparam int         FC_SHORT1_EN_BIT = 4;
  localparam int         FC_MASK_LSB      = 5;
  localparam int         FC_MASK_MSB      = 7;
  localparam logic [7:0] FILTER_OFF       = 8'h00;

  // rejected packet counter
  localparam logic [9:0] REJ_CNT_MAX  = 10'h3ff;
  localparam logic [9:0] REJ_CNT_ZERO = 10'h000;
  localparam logic [9:0] REJ_CNT_ONE  = 10'h001;

  // serial framing
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam logic [2:0] BIT_LAST  = 3'h7;
  localparam logic [2:0] BIT_ONE   = 3'h1;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ADDR,
    ST_DATA
  } afr_state_t;

endpackage : afr_pkg

// ==== rtl/afr_spi_filter_regs.sv ====
// Behaviour
// [RULE1] long address bytes 7 and 8 at 0x69/0x6a, used only with long check enabled
// [RULE2] short address zero from 0x6b low and 0x6c high, used when enable bit 3 set
// [RULE3] short address one from 0x6d low and 0x6e high, used when enable bit 4 set
// [RULE4] count rejected packets, read-only low/high bytes, saturating at 1023
// [RULE5] phy reset clears the rejected packet count
// [RULE6] filter control equal to zero clears the rejected packet count
// [RULE7] match registers reset to zero and are read/write; count bytes read-only
// [RULE8] serial slave on host clock, single and burst register and fifo access
// [RULE9] a written byte commits on the clock rise that samples its last bit
// [RULE10] chip select rising mid-write leaves the target register untouched
// [RULE11] chip select low keeps burst; address advances by one per byte
// [RULE12] chip select rising before the last bit aborts the byte
// [RULE13] fifo windows 0x7e and 0x7f hold the address through a burst
// [RULE14] host reads one extra byte from receive fifo in older packet mode; not implemented, 0x7f reads pop one entry per byte only
// [RULE15] enabled short check accepts only equal destination short address
// [RULE16] long check skips the low bytes counted by the three-bit mask
// [RULE17] address byte with direction bit first, msb first, opposite clock edges; the code takes the direction bit last
// [RULE18] count high byte is captured with low byte so reads stay consistent
`timescale 1ns/1ps
module afr_spi_filter_regs #(
  parameter int DATA_W    = 8,
  parameter int BUF_DEPTH = 2
) (
  // clock and reset
  input  wire logic              i_clk,
  input  wire logic              i_resetn,
  // serial link
  input  wire logic              i_sclk,
  input  wire logic              i_chip_select_n,
  input  wire logic              i_mosi,
  output logic                   o_miso,
  output logic                   o_miso_oe,
  // rest of the filter bank
  input  wire logic [7:0]        i_filter_control_reg,
  input  wire logic [47:0]       i_long_addr_low,
  input  wire logic              i_phy_reset,
  // received packet destination
  input  wire logic              i_rx_pkt_valid,
  input  wire logic              i_rx_dst_is_long,
  input  wire logic [15:0]       i_rx_dst_short,
  input  wire logic [63:0]       i_rx_dst_long,
  output logic                   o_rx_accept,
  output logic                   o_rx_discard,
  // transmit fifo stream
  output logic                   o_txf_valid,
  output logic [DATA_W-1:0]      o_txf_data,
  input  wire logic              i_txf_ready,
  output logic                   o_txf_overrun,
  // receive fifo stream
  input  wire logic              i_rxf_valid,
  input  wire logic [DATA_W-1:0] i_rxf_data,
  output logic                   o_rxf_ready
);

  localparam int PTR_W = (BUF_DEPTH > 1) ? $clog2(BUF_DEPTH) : 1;
  localparam int CNT_W = $clog2(BUF_DEPTH + 1);
  localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(BUF_DEPTH - 1);
  localparam logic [PTR_W-1:0] PTR_ZERO = '0;
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(BUF_DEPTH);
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;
  localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);
  // byte lanes of the long match address
  localparam int LONG_BYTES = 8;
  localparam int BYTE_W     = 8;

  // input synchronisers
  logic       sclk_s1_ff;
  logic       sclk_s2_ff;
  logic       sclk_d_ff;
  logic       csn_s1_ff;
  logic       csn_s2_ff;
  logic       mosi_s1_ff;
  logic       mosi_s2_ff;

  // serial engine
  afr_pkg::afr_state_t state_ff;
  logic [2:0] bit_cnt_ff;
  logic [6:0] shift_in_ff;
  logic [6:0] addr_ff;
  logic       is_write_ff;
  logic       load_pend_ff;
  logic [7:0] shift_out_ff;
  logic       miso_oe_ff;

  // register bank
  logic [7:0] rw_ff [afr_pkg::RW_COUNT];
  logic [9:0] rej_cnt_ff;
  logic [1:0] rej_hi_shadow_ff;
  logic       accept_ff;
  logic       discard_ff;
  logic       overrun_ff;

  // transmit buffer
  logic [DATA_W-1:0] buf_ff [BUF_DEPTH];
  logic [PTR_W-1:0]  wr_ptr_ff;
  logic [PTR_W-1:0]  rd_ptr_ff;
  logic [CNT_W-1:0]  buf_cnt_ff;

  logic       sclk_rise;
  logic       sclk_fall;
  logic       cs_active;
  logic       byte_done;
  logic [7:0] byte_in;
  logic       wr_commit;
  logic       rxf_pop;
  logic [6:0] nxt_addr;
  logic       buf_in_ready;
  logic       buf_push;
  logic       buf_pop;
  logic       pkt_accept;
  logic       txf_write;
  logic       rd_next;

  function automatic logic is_rw_addr(input logic [6:0] a);
    return (a >= afr_pkg::ADDR_LONG_BYTE7) && (a <= afr_pkg::ADDR_SHORT1_HIGH);
  endfunction : is_rw_addr

  function automatic int rw_index(input logic [6:0] a);
    return int'(a - afr_pkg::ADDR_LONG_BYTE7);
  endfunction : rw_index

  function automatic logic [PTR_W-1:0] ptr_next(input logic [PTR_W-1:0] p);
    return (p == PTR_LAST) ? PTR_ZERO : PTR_W'(p + PTR_W'(1));
  endfunction : ptr_next

  function automatic logic is_fifo_addr(input logic [6:0] a);
    return (a == afr_pkg::ADDR_TX_FIFO) || (a == afr_pkg::ADDR_RX_FIFO);
  endfunction : is_fifo_addr

  // sample the host signals into the local clock
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      sclk_s1_ff <= 1'b0;
      sclk_s2_ff <= 1'b0;
      sclk_d_ff  <= 1'b0;
      csn_s1_ff  <= 1'b1;
      csn_s2_ff  <= 1'b1;
      mosi_s1_ff <= 1'b0;
      mosi_s2_ff <= 1'b0;
    end else begin
      sclk_s1_ff <= i_sclk;
      sclk_s2_ff <= sclk_s1_ff;
      sclk_d_ff  <= sclk_s2_ff;
      csn_s1_ff  <= i_chip_select_n;
      csn_s2_ff  <= csn_s1_ff;
      mosi_s1_ff <= i_mosi;
      mosi_s2_ff <= mosi_s1_ff;
    end
  end

  assign sclk_rise = sclk_s2_ff && !sclk_d_ff;
  assign sclk_fall = !sclk_s2_ff && sclk_d_ff;
  assign cs_active = !csn_s2_ff;
  // a byte only completes on the rise of its last bit with select still low
  assign byte_done = cs_active && sclk_rise && (bit_cnt_ff == afr_pkg::BIT_LAST); // see [RULE12]
  assign byte_in   = {shift_in_ff, mosi_s2_ff};
  assign wr_commit = byte_done && (state_ff == afr_pkg::ST_DATA) && is_write_ff; // see [RULE9]
  assign rxf_pop   = byte_done && (state_ff == afr_pkg::ST_DATA) && !is_write_ff
                     && (addr_ff == afr_pkg::ADDR_RX_FIFO) && i_rxf_valid;
  assign o_rxf_ready = rxf_pop;
  // the byte that just ended is followed by a read byte
  assign rd_next   = byte_done && !(state_ff == afr_pkg::ST_ADDR ? mosi_s2_ff : is_write_ff);

  // fifo windows keep their address, others advance
  always_comb begin
    if (is_fifo_addr(addr_ff)) begin
      nxt_addr = addr_ff; // see [RULE13]
    end else begin
      nxt_addr = 7'(addr_ff + afr_pkg::ADDR_ONE); // see [RULE11]
    end
  end

  // framing: address byte then data bytes, msb first on rising edges
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      state_ff    <= afr_pkg::ST_IDLE;
      bit_cnt_ff  <= afr_pkg::BIT_FIRST;
      shift_in_ff <= 7'h00;
      addr_ff     <= 7'h00;
      is_write_ff <= 1'b0;
    end else if (!cs_active) begin
      state_ff   <= afr_pkg::ST_IDLE; // see [RULE10]
      bit_cnt_ff <= afr_pkg::BIT_FIRST; // see [RULE12]
    end else begin
      if (state_ff == afr_pkg::ST_IDLE) begin
        state_ff <= afr_pkg::ST_ADDR; // see [RULE8]
      end
      if (sclk_rise && (state_ff != afr_pkg::ST_IDLE)) begin
        shift_in_ff <= byte_in[6:0]; // see [RULE17]
        bit_cnt_ff  <= 3'(bit_cnt_ff + afr_pkg::BIT_ONE);
      end
      if (byte_done && (state_ff == afr_pkg::ST_ADDR)) begin
        addr_ff     <= shift_in_ff; // see [RULE17]
        is_write_ff <= mosi_s2_ff;
        state_ff    <= afr_pkg::ST_DATA;
      end else if (byte_done && (state_ff == afr_pkg::ST_DATA)) begin
        addr_ff <= nxt_addr; // see [RULE11]
      end
    end
  end

  // read data: loaded one cycle after a byte ends, shifted out on falling edges
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      load_pend_ff     <= 1'b0;
      shift_out_ff     <= afr_pkg::READ_ZERO;
      miso_oe_ff       <= 1'b0;
      rej_hi_shadow_ff <= 2'h0;
    end else begin
      load_pend_ff <= rd_next;
      miso_oe_ff   <= cs_active && (state_ff == afr_pkg::ST_DATA) && !is_write_ff;
      if (load_pend_ff) begin
        if (is_rw_addr(addr_ff)) begin
          shift_out_ff <= rw_ff[rw_index(addr_ff)]; // see [RULE7]
        end else if (addr_ff == afr_pkg::ADDR_REJ_CNT_LOW) begin
          shift_out_ff     <= rej_cnt_ff[7:0]; // see [RULE4]
          rej_hi_shadow_ff <= rej_cnt_ff[9:8]; // see [RULE18]
        end else if (addr_ff == afr_pkg::ADDR_REJ_CNT_HIGH) begin
          shift_out_ff <= {6'h00, rej_hi_shadow_ff}; // see [RULE18]
        end else if ((addr_ff == afr_pkg::ADDR_RX_FIFO) && i_rxf_valid) begin
          shift_out_ff <= i_rxf_data; // see [RULE8]
        end else begin
          shift_out_ff <= afr_pkg::READ_ZERO;
        end
      end else if (sclk_fall && cs_active && (bit_cnt_ff != afr_pkg::BIT_FIRST)) begin
        shift_out_ff <= {shift_out_ff[6:0], 1'b0}; // see [RULE17]
      end
    end
  end

  assign o_miso    = shift_out_ff[7];
  assign o_miso_oe = miso_oe_ff;

  // match registers, written only by a completed byte
  generate
    for (genvar g = 0; g < afr_pkg::RW_COUNT; g++) begin : g_rw
      always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
          rw_ff[g] <= afr_pkg::REG_RESET; // see [RULE7]
        end else if (wr_commit && is_rw_addr(addr_ff) && (rw_index(addr_ff) == g)) begin
          rw_ff[g] <= byte_in; // see [RULE9]
        end
      end
    end
  endgenerate

  // address check against the programmed match values
  always_comb begin
    logic        long_ok;
    logic [2:0]  mask;
    logic [63:0] long_val;
    logic        sh0_en;
    logic        sh1_en;
    long_ok  = 1'b1;
    mask     = i_filter_control_reg[afr_pkg::FC_MASK_MSB:afr_pkg::FC_MASK_LSB];
    long_val = {rw_ff[1], rw_ff[0], i_long_addr_low}; // see [RULE1]
    sh0_en   = i_filter_control_reg[afr_pkg::FC_SHORT0_EN_BIT];
    sh1_en   = i_filter_control_reg[afr_pkg::FC_SHORT1_EN_BIT];
    for (int b = 0; b < LONG_BYTES; b++) begin
      if ((3'(b) >= mask)
          && (long_val[b*BYTE_W +: BYTE_W] != i_rx_dst_long[b*BYTE_W +: BYTE_W])) begin
        long_ok = 1'b0; // see [RULE16]
      end
    end
    if (i_rx_dst_is_long) begin
      pkt_accept = !i_filter_control_reg[afr_pkg::FC_LONG_EN_BIT] || long_ok; // see [RULE1]
    end else begin
      pkt_accept = !(sh0_en || sh1_en)
        || (sh0_en && (i_rx_dst_short == {rw_ff[3], rw_ff[2]})) // see [RULE2] [RULE15]
        || (sh1_en && (i_rx_dst_short == {rw_ff[5], rw_ff[4]})); // see [RULE3] [RULE15]
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      accept_ff  <= 1'b0;
      discard_ff <= 1'b0;
    end else begin
      accept_ff  <= i_rx_pkt_valid && pkt_accept;
      discard_ff <= i_rx_pkt_valid && !pkt_accept;
    end
  end

  assign o_rx_accept  = accept_ff;
  assign o_rx_discard = discard_ff;

  // rejected packet counter
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      rej_cnt_ff <= afr_pkg::REJ_CNT_ZERO; // see [RULE7]
    end else if (i_phy_reset) begin
      rej_cnt_ff <= afr_pkg::REJ_CNT_ZERO; // see [RULE5]
    end else if (i_filter_control_reg == afr_pkg::FILTER_OFF) begin
      rej_cnt_ff <= afr_pkg::REJ_CNT_ZERO; // see [RULE6]
    end else if (discard_ff && (rej_cnt_ff != afr_pkg::REJ_CNT_MAX)) begin
      rej_cnt_ff <= 10'(rej_cnt_ff + afr_pkg::REJ_CNT_ONE); // see [RULE4]
    end
  end

  // two-entry transmit buffer in front of the transmit fifo
  assign buf_in_ready = (buf_cnt_ff != CNT_FULL);
  assign txf_write    = wr_commit && (addr_ff == afr_pkg::ADDR_TX_FIFO); // see [RULE13]
  assign buf_push     = txf_write && buf_in_ready;
  assign buf_pop      = o_txf_valid && i_txf_ready;
  assign o_txf_valid  = (buf_cnt_ff != CNT_ZERO);

  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      wr_ptr_ff  <= PTR_ZERO;
      rd_ptr_ff  <= PTR_ZERO;
      buf_cnt_ff <= CNT_ZERO;
    end else begin
      if (buf_push) begin
        buf_ff[wr_ptr_ff] <= byte_in; // see [RULE13]
        wr_ptr_ff         <= ptr_next(wr_ptr_ff);
      end
      if (buf_pop) begin
        rd_ptr_ff <= ptr_next(rd_ptr_ff);
      end
      if (buf_push && !buf_pop) begin
        buf_cnt_ff <= CNT_W'(buf_cnt_ff + CNT_ONE);
      end else if (buf_pop && !buf_push) begin
        buf_cnt_ff <= CNT_W'(buf_cnt_ff - CNT_ONE);
      end
    end
  end

  assign o_txf_data = buf_ff[rd_ptr_ff];

  // sticky overrun: a transmit byte arrived while the buffer was full
  always_ff @(posedge i_clk) begin
    if (!i_resetn) begin
      overrun_ff <= 1'b0;
    end else if (txf_write && !buf_in_ready) begin
      overrun_ff <= 1'b1;
    end else if (i_phy_reset) begin
      overrun_ff <= 1'b0;
    end
  end

  assign o_txf_overrun = overrun_ff;

endmodule : afr_spi_filter_regs

// ==== tb/afr_chk.sv ====
`timescale 1ns/1ps
module afr_chk #(
  parameter int DATA_W = 8
) (
  // clock, reset, link
  input wire logic              i_clk,
  input wire logic              i_resetn,
  input wire logic              i_chip_select_n,
  input wire logic              o_miso_oe,
  // packet check
  input wire logic              i_phy_reset,
  input wire logic              i_rx_pkt_valid,
  input wire logic              o_rx_accept,
  input wire logic              o_rx_discard,
  // fifo streams
  input wire logic              o_txf_valid,
  input wire logic [DATA_W-1:0] o_txf_data,
  input wire logic              i_txf_ready,
  input wire logic              o_txf_overrun,
  input wire logic              i_rxf_valid,
  input wire logic              o_rxf_ready
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  oe_idle_a: assert property (i_chip_select_n [*5] |-> !o_miso_oe)
    else $error("miso driven while deselected");
  verdict_excl_a: assert property (!(o_rx_accept && o_rx_discard))
    else $error("accept and discard together");
  verdict_cause_a: assert property ((o_rx_accept || o_rx_discard) |-> $past(i_rx_pkt_valid))
    else $error("verdict without packet");
  verdict_given_a: assert property (i_rx_pkt_valid |=> (o_rx_accept || o_rx_discard))
    else $error("packet without verdict");
  txf_hold_a: assert property (o_txf_valid && !i_txf_ready |=> o_txf_valid && $stable(o_txf_data))
    else $error("transmit head lost while stalled");
  overrun_keep_a: assert property (o_txf_overrun && !i_phy_reset |=> o_txf_overrun)
    else $error("overrun flag dropped");
  pop_valid_a: assert property (o_rxf_ready |-> i_rxf_valid)
    else $error("pop of empty receive fifo");
  pop_frame_a: assert property (o_rxf_ready |-> !i_chip_select_n)
    else $error("pop outside a frame");
  pop_pulse_a: assert property (o_rxf_ready |=> !o_rxf_ready)
    else $error("pop longer than one cycle");
endmodule : afr_chk

// ==== tb/afr_host.sv ====
`timescale 1ns/1ps
module afr_host (
  // serial link, host side
  output logic      o_sclk,
  output logic      o_chip_select_n,
  output logic      o_mosi,
  input  wire logic i_miso
);
  logic [7:0] wd [8];
  logic [7:0] rd [8];
  initial begin
    o_sclk = 1'b0;
    o_chip_select_n = 1'b1;
    o_mosi = 1'b0;
  end
  // one byte msb first, nb bits only; clock idles low
  task automatic xbyte(input logic [7:0] tx, input int nb, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 0; i < nb; i++) begin
      o_mosi = tx[7-i];
      #32 o_sclk = 1'b1;
      rx = {rx[6:0], i_miso};
      #32 o_sclk = 1'b0;
    end
  endtask : xbyte
  // address byte, then n data bytes under one select; last byte cut to nb bits
  task automatic frame(input logic [6:0] a, input logic w, input int n, input int nb);
    logic [7:0] junk;
    o_chip_select_n = 1'b0;
    #40 xbyte({a, w}, 8, junk);
    for (int k = 0; k < n; k++) begin
      xbyte(wd[k], (k == n - 1) ? nb : 8, rd[k]);
    end
    #40 o_chip_select_n = 1'b1;
    o_mosi = ~o_mosi;
    #120;
  endtask : frame
endmodule : afr_host

// ==== tb/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  localparam int DATA_W = 8;
  logic        clk, rstn, phy, pv, isl, tr, miso, oe, acc, dis, tv, tov, rr, sclk, csn, mosi;
  logic [7:0]  fc, td;
  logic [15:0] ds, sa;
  logic [47:0] lal;
  logic [63:0] dl, la;
  logic [31:0] seed, t;
  logic [7:0]  mem [8];
  logic [7:0]  rq [4];
  int          miscompares, cmp_count, cyc, ri, rn, d;
  // a released miso line shows the inverse of the last driven bit
  afr_host host (.o_sclk(sclk), .o_chip_select_n(csn), .o_mosi(mosi),
                 .i_miso(oe ? miso : ~miso));
  afr_spi_filter_regs #(.DATA_W(DATA_W), .BUF_DEPTH(2)) uut (
    .i_clk(clk), .i_resetn(rstn), .i_sclk(sclk), .i_chip_select_n(csn), .i_mosi(mosi),
    .o_miso(miso), .o_miso_oe(oe), .i_filter_control_reg(fc), .i_long_addr_low(lal),
    .i_phy_reset(phy), .i_rx_pkt_valid(pv), .i_rx_dst_is_long(isl), .i_rx_dst_short(ds),
    .i_rx_dst_long(dl), .o_rx_accept(acc), .o_rx_discard(dis), .o_txf_valid(tv),
    .o_txf_data(td), .i_txf_ready(tr), .o_txf_overrun(tov), .i_rxf_valid(ri < rn),
    .i_rxf_data(rq[ri % 4]), .o_rxf_ready(rr));
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    if (rr && ri < rn) ri <= ri + 1;
    cyc++;
    if (cyc == 40000) begin
      miscompares++;
      test_done();
    end
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  function automatic logic exp_acc(input logic il, input logic [15:0] s, input logic [63:0] l);
    logic [63:0] m;
    m = ~64'h0 << (8 * fc[7:5]);
    if (il) return !fc[2] || ((l & m) === (la & m));
    return !(fc[3] || fc[4]) || (fc[3] && (s === {mem[3], mem[2]}))
           || (fc[4] && (s === {mem[5], mem[4]}));
  endfunction : exp_acc
  task automatic chk(input logic [15:0] s, input logic [15:0] x);
    cmp_count++;
    if (s !== x) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, s, x);
    end
  endtask : chk
  task automatic fr(input logic [6:0] a, input logic w, input int n, input int nb);
    host.frame(a, w, n, nb);
    @(posedge clk);
    #1;
  endtask : fr
  task automatic pkt(input logic il, input logic [15:0] s, input logic [63:0] l);
    logic e;
    e = exp_acc(il, s, l);
    isl = il;
    ds = s;
    dl = l;
    pv = 1'b1;
    @(posedge clk);
    #1 pv = 1'b0;
    chk(acc, e);
    chk(dis, !e);
    if (!e && d < 1023) d++;
    @(posedge clk);
    #1;
  endtask : pkt
  task automatic cnt(input int v);
    fr(7'h6f, 1'b0, 2, 8);
    chk(host.rd[0], v[7:0]);
    chk(host.rd[1], {6'h0, v[9:8]});
  endtask : cnt
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : test_done
  initial begin
    seed = 32'had8aeb3f;
    {clk, rstn, phy, pv, isl, tr, fc, ds, dl, d, ri, rn} = '0;
    lal = {xs(), xs()};
    repeat (5) @(posedge clk);
    #1 rstn = 1'b1;
    repeat (4) @(posedge clk);
    #1 fr(7'h69, 1'b0, 8, 8);
    for (int k = 0; k < 8; k++) chk(host.rd[k], 8'h00);
    $display("reset values done");
    for (int k = 0; k < 8; k++) host.wd[k] = xs();
    for (int k = 0; k < 8; k++) mem[k] = (k < 6) ? host.wd[k] : 8'h00;
    fr(7'h69, 1'b1, 8, 8);
    fr(7'h69, 1'b0, 8, 8);
    for (int k = 0; k < 8; k++) chk(host.rd[k], mem[k]);
    host.wd[0] = ~mem[0];
    fr(7'h69, 1'b1, 1, 7);
    fr(7'h69, 1'b0, 1, 8);
    chk(host.rd[0], mem[0]);
    $display("register access done");
    la = {mem[1], mem[0], lal};
    for (int j = 0; j < 4; j++) begin
      t = xs();
      fc = (j == 0) ? 8'h08 : (j == 1) ? 8'h10 : (j == 2) ? {t[2:0], 5'h04} : 8'h18;
      for (int i = 0; i < 8; i++) begin
        t = xs();
        sa = (j == 1 || i % 4 == 3) ? {mem[5], mem[4]} : {mem[3], mem[2]};
        pkt(j == 2 || i == 6, (i % 2) ? sa : t[15:0],
            (i % 2) ? la ^ {48'h0, t[15:0]} : {t, xs()});
      end
    end
    cnt(d);
    fc = 8'h00;
    d = 0;
    cnt(d);
    $display("address filter done");
    for (int k = 0; k < 3; k++) host.wd[k] = xs();
    fr(7'h7e, 1'b1, 3, 8);
    chk(tov, 1'b1);
    for (int k = 0; k < 2; k++) begin
      chk(tv, 1'b1);
      chk(td, host.wd[k]);
      tr = 1'b1;
      @(posedge clk);
      #1 tr = 1'b0;
      @(posedge clk);
      #1;
    end
    chk(tv, 1'b0);
    for (int k = 0; k < 4; k++) rq[k] = xs();
    rn = 3;
    fr(7'h7f, 1'b0, 4, 8);
    for (int k = 0; k < 4; k++) chk(host.rd[k], (k < 3) ? rq[k] : 8'h00);
    chk(ri, 3);
    $display("fifo windows done");
    fc = 8'h08;
    sa = {mem[3], mem[2]};
    repeat (1030) pkt(1'b0, ~sa, 64'h0);
    cnt(d);
    phy = 1'b1;
    @(posedge clk);
    #1 phy = 1'b0;
    d = 0;
    cnt(d);
    chk(tov, 1'b0);
    chk(oe, 1'b0);
    $display("count limits done");
    test_done();
  end
endmodule : testbench
bind afr_spi_filter_regs afr_chk #(.DATA_W(DATA_W)) u_chk (
  .i_clk(i_clk), .i_resetn(i_resetn), .i_chip_select_n(i_chip_select_n),
  .o_miso_oe(o_miso_oe), .i_phy_reset(i_phy_reset), .i_rx_pkt_valid(i_rx_pkt_valid),
  .o_rx_accept(o_rx_accept), .o_rx_discard(o_rx_discard), .o_txf_valid(o_txf_valid),
  .o_txf_data(o_txf_data), .i_txf_ready(i_txf_ready), .o_txf_overrun(o_txf_overrun),
  .i_rxf_valid(i_rxf_valid), .o_rxf_ready(o_rxf_ready));
